/* File: mwf_pkg.sv */
// Package for the multiply-working-by-file execution block.
// Assumes a single core clock; shared by the datapath and its multiplier leaf.
package mwf_pkg;
    localparam int DATA_W = 8;
    localparam int PROD_W = 16;
    localparam int INSN_W = 16;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam logic [6:0] OPC_MUL_FILE_TOP = 7'h01;
    localparam int FADDR_W = 8;
    localparam int OPC_POS = 9;
    localparam int ACC_POS = 8;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [7:0] PROD_RST = 8'h00;
    localparam logic [1:0] PH_RST = 2'h0;

    typedef enum logic [1:0] {
        MWF_Q1_DECODE = 2'b00,
        MWF_Q2_READ = 2'b01,
        MWF_Q3_PROCESS = 2'b10,
        MWF_Q4_WRITE = 2'b11
    } mwf_phase_e;
endpackage

/* File: mwf_multiplier.sv */
// Unsigned multiplier leaf: registered product of two operand bytes.
// Assumes operands stand stable in the cycle that loadEn is high.
module mwf_multiplier #(
    parameter int WIDTH = mwf_pkg::DATA_W
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic loadEn,
    input wire logic [WIDTH-1:0] opA,
    input wire logic [WIDTH-1:0] opB,
    output logic [2*WIDTH-1:0] product
);
    import mwf_pkg::*;

    logic [2*WIDTH-1:0] product_ff;
    // Operands widened first so the product is formed at full width
    wire logic [2*WIDTH-1:0] nxt_product = loadEn ?
        {{WIDTH{1'b0}}, opA} * {{WIDTH{1'b0}}, opB} : product_ff;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            product_ff <= '0;
        end else begin
            product_ff <= nxt_product;
        end
    end

    assign product = product_ff;
endmodule

/* File: mwf_exec.sv */
// Execution block for the multiply-working-by-file instruction.
// Assumes the core presents an instruction word in Q1 of the block's own free-running four-phase cycle;
// data memory answers a read address combinationally within one core clock.

module mwf_exec (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic insnValid,
    input wire logic [mwf_pkg::INSN_W-1:0] insnWord,
    input wire logic [mwf_pkg::DATA_W-1:0] workingReg,
    input wire logic [mwf_pkg::BANK_W-1:0] bankSelectReg,
    input wire logic extendedEn,
    input wire logic [mwf_pkg::ADDR_W-1:0] indexBase,
    input wire logic [mwf_pkg::DATA_W-1:0] fileRdData,
    output logic [mwf_pkg::ADDR_W-1:0] fileRdAddr,
    output logic fileRdEn,
    output logic [1:0] phase,
    output logic busy,
    output logic productHighByte,
    output logic [mwf_pkg::DATA_W-1:0] productHigh,
    output logic [mwf_pkg::DATA_W-1:0] productLow,
    output logic productWrite
);
    import mwf_pkg::*;

    localparam int NUM_OPS = 2;
    localparam int NUM_BYTES = PROD_W / DATA_W;

    // Phase round state
    mwf_phase_e phase_ff;
    mwf_phase_e nxt_phase;
    logic active_ff;
    logic nxt_active;

    // Latched instruction word
    logic [INSN_W-1:0] insn_ff;
    logic [INSN_W-1:0] nxt_insn;

    // Operand capture sources and outputs, working register first
    wire logic [DATA_W-1:0] capSrc [NUM_OPS];
    wire logic [DATA_W-1:0] capOut [NUM_OPS];

    // Product bytes, low byte first, and the write pulse
    logic [PROD_W-1:0] mulOut;
    wire logic [DATA_W-1:0] prodOut [NUM_BYTES];
    logic wr_ff;
    logic nxt_wr;

    // Decode nets
    logic accessBit;
    logic [FADDR_W-1:0] fAddr;
    logic useIndexed;
    logic [ADDR_W-1:0] idxAddr;
    logic [BANK_W-1:0] accBank;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] bankAddr;
    logic isOpcode;
    logic startOp;
    logic inQ1;
    logic inQ2;
    logic inQ3;
    logic inQ4;

    // Only the top seven bits name the instruction; the rest are operands
    function automatic logic isMulFile(input logic [INSN_W-1:0] w);
        return w[INSN_W-1:OPC_POS] == OPC_MUL_FILE_TOP;
    endfunction

    function automatic logic atPhase(input mwf_phase_e cur, input mwf_phase_e want);
        return cur == want;
    endfunction

    // Q2 to Q4 only count while a multiply is in flight
    assign inQ1 = atPhase(phase_ff, MWF_Q1_DECODE);
    assign inQ2 = active_ff && atPhase(phase_ff, MWF_Q2_READ);
    assign inQ3 = active_ff && atPhase(phase_ff, MWF_Q3_PROCESS);
    assign inQ4 = active_ff && atPhase(phase_ff, MWF_Q4_WRITE);
    assign isOpcode = isMulFile(insnWord);
    assign startOp = inQ1 && insnValid && isOpcode;

    // Operand address resolution from the latched word
    assign accessBit = insn_ff[ACC_POS];
    assign fAddr = insn_ff[FADDR_W-1:0];
    assign useIndexed = !accessBit && extendedEn && (fAddr <= IDX_LIMIT);
    assign idxAddr = indexBase + {{(ADDR_W-FADDR_W){1'b0}}, fAddr};
    // Access bank: bank 0 below the split, the last bank at and above it
    assign accBank = (fAddr < ACCESS_SPLIT) ? '0 : ACCESS_HI_BANK;
    assign bank = accessBit ? bankSelectReg : accBank;
    assign bankAddr = {bank, fAddr};

    // Free-running four-phase round
    always_comb begin
        case (phase_ff)
            MWF_Q1_DECODE: begin
                nxt_phase = MWF_Q2_READ;
            end
            MWF_Q2_READ: begin
                nxt_phase = MWF_Q3_PROCESS;
            end
            MWF_Q3_PROCESS: begin
                nxt_phase = MWF_Q4_WRITE;
            end
            MWF_Q4_WRITE: begin
                nxt_phase = MWF_Q1_DECODE;
            end
            default: begin
                nxt_phase = MWF_Q1_DECODE;
            end
        endcase
    end

    // In flight from the Q1 that takes the word to the Q4 that retires it
    always_comb begin
        if (inQ1) begin
            nxt_active = startOp;
        end else if (inQ4) begin
            nxt_active = 1'b0;
        end else begin
            nxt_active = active_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            phase_ff <= MWF_Q1_DECODE;
            active_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            active_ff <= nxt_active;
        end
    end

    // Word held from Q1 so the address stays put while memory answers in Q2
    assign nxt_insn = startOp ? insnWord : insn_ff;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            insn_ff <= '0;
        end else begin
            insn_ff <= nxt_insn;
        end
    end

    // Both operands are copied in Q2; neither source is ever written back
    assign capSrc[0] = workingReg;
    assign capSrc[1] = fileRdData;

    for (genvar g = 0; g < NUM_OPS; g++) begin : gen_capture
        logic [DATA_W-1:0] opnd_ff;
        logic [DATA_W-1:0] nxt_opnd;

        assign nxt_opnd = inQ2 ? capSrc[g] : opnd_ff;

        always_ff @(posedge core_clk) begin
            if (!reset_n) begin
                opnd_ff <= '0;
            end else begin
                opnd_ff <= nxt_opnd;
            end
        end

        assign capOut[g] = opnd_ff;
    end

    // Multiply in Q3; carry and overflow are impossible so no flags leave here
    mwf_multiplier #(.WIDTH(DATA_W)) uMul (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .loadEn(inQ3),
        .opA(capOut[0]),
        .opB(capOut[1]),
        .product(mulOut)
    );

    // Every byte shares the one Q4 load, so a torn product is never visible
    for (genvar g = 0; g < NUM_BYTES; g++) begin : gen_product
        logic [DATA_W-1:0] prodByte_ff;
        logic [DATA_W-1:0] nxt_prodByte;

        assign nxt_prodByte = inQ4 ? mulOut[g*DATA_W +: DATA_W] : prodByte_ff;

        always_ff @(posedge core_clk) begin
            if (!reset_n) begin
                prodByte_ff <= PROD_RST;
            end else begin
                prodByte_ff <= nxt_prodByte;
            end
        end

        assign prodOut[g] = prodByte_ff;
    end

    assign nxt_wr = inQ4;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wr_ff <= 1'b0;
        end else begin
            wr_ff <= nxt_wr;
        end
    end

    // Read only in Q2; no write port to file or working register exists
    assign fileRdAddr = useIndexed ? idxAddr : bankAddr;
    assign fileRdEn = inQ2;
    assign phase = phase_ff;
    assign busy = active_ff;
    // Zero products are written like any other; no zero output exists, only productHighByte for a non-zero high byte
    assign productHighByte = |prodOut[1];
    assign productHigh = prodOut[1];
    assign productLow = prodOut[0];
    assign productWrite = wr_ff;
endmodule

/* File: mwf_mem_model.sv */
// Data memory stand-in for the multiply block.
// Assumes one core clock; away from a read the data line churns.
module mwf_mem_model (
    input wire logic core_clk,
    input wire logic [11:0] fileRdAddr,
    input wire logic fileRdEn,
    output logic [7:0] fileRdData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] churn_ff = 8'h00;
    always @(posedge core_clk) churn_ff <= churn_ff + 8'h5B;
    assign fileRdData = fileRdEn ? fileRdAddr[7:0] ^ {fileRdAddr[11:8], 4'h6} : churn_ff;
endmodule

/* File: mwf_exec_sva.sv */
// Port checker for the multiply block.
// Assumes operands are held for a whole four-phase round.
module mwf_exec_sva (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic insnValid,
    input wire logic [15:0] insnWord,
    input wire logic [7:0] workingReg,
    input wire logic [3:0] bankSelectReg,
    input wire logic extendedEn,
    input wire logic [11:0] indexBase,
    input wire logic [7:0] fileRdData,
    input wire logic [11:0] fileRdAddr,
    input wire logic fileRdEn,
    input wire logic [1:0] phase,
    input wire logic busy,
    input wire logic productHighByte,
    input wire logic [7:0] productHigh,
    input wire logic [7:0] productLow,
    input wire logic productWrite
);
    logic [8:0] insn_ff;
    wire logic take = phase == 2'h0 && insnValid && insnWord[15:9] == 7'h01;
    always_ff @(posedge core_clk) insn_ff <= insnWord[8:0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    prod_value_a: assert property (productWrite |-> {productHigh, productLow} ==
        {8'h00, $past(workingReg, 3)} * {8'h00, $past(fileRdData, 3)}) else $error("product");
    prod_hold_a: assert property (!productWrite |->
        $stable({productHigh, productLow})) else $error("hold");
    write_time_a: assert property ($rose(busy) |-> ##3 productWrite && !busy)
        else $error("timing");
    read_phase_a: assert property (fileRdEn |-> phase == 2'h1 && busy)
        else $error("read phase");
    take_insn_a: assert property (take |=> fileRdEn) else $error("take");
    refuse_insn_a: assert property (phase == 2'h0 && !take |=> !busy ##3 !productWrite)
        else $error("refuse");
    bank_addr_a: assert property (fileRdEn && insn_ff[8] |->
        fileRdAddr == {bankSelectReg, insn_ff[7:0]}) else $error("bank");
    index_addr_a: assert property (fileRdEn && !insn_ff[8] && extendedEn &&
        insn_ff[7:0] <= 8'h5F |-> fileRdAddr == indexBase + insn_ff[7:0]) else $error("index");
    access_addr_a: assert property (fileRdEn && !insn_ff[8] &&
        !(extendedEn && insn_ff[7:0] <= 8'h5F) |->
        fileRdAddr == {((insn_ff[7:0] >= 8'h60) ? 4'hF : 4'h0), insn_ff[7:0]})
        else $error("access bank");
    high_byte_a: assert property (productHighByte == |productHigh)
        else $error("high byte in use");
endmodule
bind mwf_exec mwf_exec_sva mwf_exec_sva_inst (.core_clk, .reset_n, .insnValid, .insnWord,
    .workingReg, .bankSelectReg, .extendedEn, .indexBase, .fileRdData, .fileRdAddr,
    .fileRdEn, .phase, .busy, .productHighByte, .productHigh, .productLow, .productWrite);

/* File: mwf_exec_tb_top.sv */
// Bench for the multiply block: random rounds, expected products queued.
// Assumes the memory model and bound checker are compiled before it.
module mwf_exec_tb_top;
    import mwf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, reset_n = 1'b0, insnValid = 1'b0, extendedEn = 1'b0;
    logic [15:0] insnWord = 16'h0000;
    logic [7:0] workingReg = 8'h00;
    logic [3:0] bankSelectReg = 4'h0;
    logic [11:0] indexBase = 12'h000, fileRdAddr;
    logic [7:0] fileRdData, productHigh, productLow;
    logic [1:0] phase;
    logic fileRdEn, busy, productHighByte, productWrite;
    logic [15:0] expQ[$];
    logic [15:0] expP;
    int num_errors = 0, checks_done = 0, seed = 3;
    mwf_exec mwf_exec_inst (.core_clk, .reset_n, .insnValid, .insnWord, .workingReg,
        .bankSelectReg, .extendedEn, .indexBase, .fileRdData, .fileRdAddr, .fileRdEn,
        .phase, .busy, .productHighByte, .productHigh, .productLow, .productWrite);
    mwf_mem_model mwf_mem_model_inst (.core_clk, .fileRdAddr, .fileRdEn, .fileRdData);
    task automatic check_prod(input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] product expected %h seen %h", exp, seen);
        end
    endtask
    task automatic check_bit(input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] high byte in use expected %b seen %b", exp, seen);
        end
    endtask
    task automatic check_left(input int exp, input int seen);
        checks_done++;
        if (seen != exp) begin
            num_errors++;
            $display("[FAIL] products left expected %0d seen %0d", exp, seen);
        end
    endtask
    task automatic results;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial forever #5 core_clk = ~core_clk;
    initial begin
        #20000;
        num_errors++;
        results();
    end
    // An empty queue yields X, so a surplus write never matches
    always @(posedge core_clk) if (productWrite === 1'b1) begin
        expP = expQ.size() ? expQ.pop_front() : 16'hXXXX;
        check_prod(expP, {productHigh, productLow});
        check_bit(|expP[15:8], productHighByte);
    end
    initial begin
        logic [15:0] w;
        logic [11:0] a, ix;
        logic [7:0] wr, d;
        logic [3:0] b;
        logic e;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            do @(posedge core_clk); while (phase !== 2'h3);
            w = 16'($random(seed));
            {wr, b, e, ix} = 25'($random(seed));
            w[15:9] = (i % 6 == 5) ? 7'h03 : 7'h01;
            if (i % 5 == 0) wr = 8'h00;
            a = w[8] ? {b, w[7:0]} : (e && w[7:0] <= 8'h5F) ? ix + w[7:0] :
                {w[7:0] >= 8'h60 ? 4'hF : 4'h0, w[7:0]};
            d = a[7:0] ^ {a[11:8], 4'h6};
            if (i % 6 < 4) expQ.push_back({8'h00, wr} * {8'h00, d});
            insnWord <= w;
            insnValid <= (i % 6 != 4);
            workingReg <= wr;
            bankSelectReg <= b;
            extendedEn <= e;
            indexBase <= ix;
        end
        @(posedge core_clk);
        insnValid <= 1'b0;
        repeat (8) @(posedge core_clk);
        check_left(0, expQ.size());
        results();
    end
endmodule
